// ### quad_timer_pkg.sv
// constants shared by the quad down-counter timer
package quad_timer_pkg;
  localparam int          timer_count      = 4;
  localparam int          count_width      = 32;
  localparam int          pwm_count        = 8;
  localparam int          select_width     = 4;
  localparam int          xtal_rate_width  = 2;
  localparam int          xtal_div_width   = 5;
  localparam logic [31:0] count_reset      = 32'h0000_0000;
  localparam logic [31:0] count_one        = 32'h0000_0001;
  // tick source codes: 0..7 pwm outputs, 8 crystal tick, others never tick
  localparam logic [3:0]  select_xtal      = 4'h8;
  // crystal tick rate codes
  localparam logic [1:0]  xtal_rate_32k    = 2'h0;
  localparam logic [1:0]  xtal_rate_8k     = 2'h1;
  localparam logic [1:0]  xtal_rate_4k     = 2'h2;
  localparam logic [1:0]  xtal_rate_1k     = 2'h3;
  // crystal edges per tick, less one, for each rate
  localparam logic [4:0]  xtal_div_32k     = 5'h00;
  localparam logic [4:0]  xtal_div_8k      = 5'h03;
  localparam logic [4:0]  xtal_div_4k      = 5'h07;
  localparam logic [4:0]  xtal_div_1k      = 5'h1F;
endpackage

// ### xtal_prescaler.sv
// crystal tick prescaler: one-cycle enable at 32, 8, 4 or 1 kHz
`timescale 1ns/1ns
`default_nettype none
module xtal_prescaler
  import quad_timer_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       xtal_edge,
  input  wire logic [xtal_rate_width-1:0] rate,
  output var  logic                       tick
);
  typedef struct packed {
    logic [xtal_div_width-1:0] count;
    logic                      tick;
  } state_type;

  state_type state;
  state_type next_state;

  // divide limit for the chosen rate
  function automatic logic [xtal_div_width-1:0] div_limit(input logic [xtal_rate_width-1:0] r);
    case (r)
      xtal_rate_32k: div_limit = xtal_div_32k;
      xtal_rate_8k:  div_limit = xtal_div_8k;
      xtal_rate_4k:  div_limit = xtal_div_4k;
      default:       div_limit = xtal_div_1k;
    endcase
  endfunction

  // count crystal edges and pulse when the limit is passed
  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (xtal_edge) begin
      if (state.count >= div_limit(rate)) begin
        next_state.count = '0;
        next_state.tick  = 1'b1;
      end else begin
        next_state.count = state.count + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
endmodule
`default_nettype wire

// ### quad_down_counter_timer.sv
// four 32-bit down-counting timers with reload, match and selectable tick
// Contract
// [R1] four timers, fixed count plus running counter
// [R2] counter decrements; zero sets status bit
// [R3] reload on: copy fixed count, continue
// [R4] reload off: counter stalls at zero
// [R5] load-on-write copies written fixed count
// [R6] polarity selects rising or falling edge
// [R7] sources: pwm outputs, crystal 32/8/4/1 kHz
// [R8] counter equal match raises interrupt
// [R9] one decrement per synchronised qualified edge
// [R10] status holds until software clears
`timescale 1ns/1ns
`default_nettype none
module quad_down_counter_timer
  import quad_timer_pkg::*;
(
  input  wire logic                                      clk,
  input  wire logic                                      rst,
  input  wire logic [pwm_count-1:0]                      pwm_in,
  input  wire logic                                      xtal_in,
  input  wire logic [xtal_rate_width-1:0]                xtal_rate,
  input  wire logic [timer_count-1:0][select_width-1:0]  source_select,
  input  wire logic [timer_count-1:0]                    invert,
  input  wire logic [timer_count-1:0]                    reload,
  input  wire logic [timer_count-1:0]                    load_on_write,
  input  wire logic [timer_count-1:0]                    fixed_write,
  input  wire logic [count_width-1:0]                    fixed_data,
  input  wire logic [timer_count-1:0]                    match_write,
  input  wire logic [count_width-1:0]                    match_data,
  input  wire logic [timer_count-1:0]                    status_clear,
  input  wire logic [timer_count-1:0]                    match_clear,
  output var  logic [timer_count-1:0][count_width-1:0]   fixed_count,
  output var  logic [timer_count-1:0][count_width-1:0]   running_count,
  output var  logic [timer_count-1:0][count_width-1:0]   match_value,
  output var  logic [timer_count-1:0]                    zero_status,
  output var  logic [timer_count-1:0]                    match_status
);
  // notes for users of this block
  //  - pwm pins and the crystal pin are asynchronous; each passes two flip-flops
  //    before anything looks at it, so a pwm pin edge moves a counter three clocks later and a ticking crystal edge four
  //  - source edges closer than two clocks apart can merge into one count
  //  - the crystal source is the prescaled tick pulse: one count per tick on
  //    either polarity, the falling setting just counts one clock later
  //  - changing a running timer's source or polarity can look like an edge and
  //    cost one count; park the timer or reload it afterwards
  //  - source codes above the crystal code select a level that never moves
  //  - with reload on, the running value passes from one straight to the fixed
  //    count and never shows zero
  //  - with reload on and a fixed count of zero, the timer sits at zero and
  //    never raises its zero flag
  //  - a write to the fixed count beats a count in the same clock
  //  - both status flags are sticky, and a set in the clearing clock wins, so
  //    a clear never hides an event
  //  - the match compare runs every clock, so a counter parked on the match
  //    value keeps its flag set however often it is cleared
  //  - out of reset all counters and match values are zero, which sets every
  //    match flag on the first clock; software clears them after setup
  //  - the two flag vectors are the interrupt requests; there is no other pin

  // all state of the block except the crystal prescaler lives in one register
  typedef struct packed {
    // blocks edge detection until the previous-level register holds real levels
    logic                                       armed;
    // pin synchronisers and edge history
    logic [pwm_count-1:0]                       pwm_meta;
    logic [pwm_count-1:0]                       pwm_sync;
    logic                                       xtal_meta;
    logic                                       xtal_sync;
    logic                                       xtal_last;
    logic [timer_count-1:0]                     source_last;
    logic [timer_count-1:0][count_width-1:0]    fixed;
    logic [timer_count-1:0][count_width-1:0]    running;
    logic [timer_count-1:0][count_width-1:0]    match;
    logic [timer_count-1:0]                     zero_flag;
    logic [timer_count-1:0]                     match_flag;
  } state_type;

  state_type                         state;
  state_type                         next_state;
  logic                              xtal_edge;
  logic                              xtal_tick;
  logic [timer_count-1:0]            source_level;
  logic [timer_count-1:0]            qualified;

  // pick the tick level for one timer; the crystal source is the one-clock
  // prescaler pulse, so both of its edges come once per tick and either
  // polarity setting counts every tick
  function automatic logic source_pick(input logic [select_width-1:0] sel,
                                       input logic [pwm_count-1:0]    pwm,
                                       input logic                    xtal_level);
    if (sel < select_xtal) begin
      source_pick = pwm[sel[2:0]];
    end else if (sel == select_xtal) begin
      source_pick = xtal_level;
    end else begin
      source_pick = 1'b0;
    end
  endfunction

  // the running value that the next qualified edge takes to zero, or to the fixed count with reload on
  function automatic logic is_last(input logic [count_width-1:0] value);
    is_last = (value == count_one);                                        // [R2]
  endfunction

  // running value after one qualified edge
  function automatic logic [count_width-1:0] count_step(
      input logic [count_width-1:0] value,
      input logic [count_width-1:0] fixed,
      input logic                   again);
    if (is_last(value) || value == count_reset) begin
      // at one or zero: reload and go on, or stall at zero until software loads a value
      if (again) begin
        count_step = fixed;                                                // [R3]
      end else begin
        count_step = count_reset;                                          // [R4]
      end
    end else begin
      // plain step down by exactly one
      count_step = value - count_one;                                      // [R2] [R9]
    end
  endfunction

  // crystal rising edge after synchronisation
  assign xtal_edge = state.xtal_sync & ~state.xtal_last;

  xtal_prescaler prescaler (
    .clk       (clk),
    .rst       (rst),
    .xtal_edge (xtal_edge),
    .rate      (xtal_rate),
    .tick      (xtal_tick)
  );

  // per-timer source level, polarity, and edge qualification
  always_comb begin
    for (int t = 0; t < timer_count; t++) begin
      source_level[t] = source_pick(source_select[t], state.pwm_sync, xtal_tick)
                        ^ invert[t];                                       // [R6] [R7]
      // no edge before the previous-level register is loaded, otherwise an
      // inverted idle source would count once right after reset
      qualified[t]    = state.armed & source_level[t] & ~state.source_last[t]; // [R9]
    end
  end

  // next state of synchronisers, counters and flags
  always_comb begin
    next_state           = state;
    next_state.pwm_meta  = pwm_in;
    next_state.pwm_sync  = state.pwm_meta;                                 // [R9]
    next_state.xtal_meta = xtal_in;
    next_state.xtal_sync = state.xtal_meta;
    next_state.xtal_last = state.xtal_sync;
    // armed rises on the first clock after reset and stays high
    next_state.armed     = 1'b1;
    // remember each selected level for the next clock's edge test
    next_state.source_last = source_level;
    for (int t = 0; t < timer_count; t++) begin
      // counting: one step per qualified edge; reaching or sitting at zero
      // reloads the fixed count when reload is on, and stays at zero if not
      if (qualified[t]) begin
        next_state.running[t] = count_step(state.running[t], state.fixed[t],
                                           reload[t]);                     // [R3] [R4] [R9]
      end
      // software writes of fixed count and match; a write beats a count in
      // the same clock, so a freshly loaded value is never stepped at once
      if (fixed_write[t]) begin
        next_state.fixed[t] = fixed_data;                                  // [R1]
        if (load_on_write[t]) begin
          next_state.running[t] = fixed_data;                              // [R5]
        end
      end
      if (match_write[t]) begin
        next_state.match[t] = match_data;
      end
      // sticky flags: the clear comes first and the set after it, so a set
      // in the clearing cycle wins
      if (status_clear[t]) begin
        next_state.zero_flag[t] = 1'b0;                                    // [R10]
      end
      if (qualified[t] && is_last(state.running[t])) begin
        next_state.zero_flag[t] = 1'b1;                                    // [R2] [R10]
      end
      if (match_clear[t]) begin
        next_state.match_flag[t] = 1'b0;
      end
      // match compares the registered values on every clock
      if (state.running[t] == state.match[t]) begin
        next_state.match_flag[t] = 1'b1;                                   // [R8]
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign fixed_count   = state.fixed;
  assign running_count = state.running;
  assign match_value   = state.match;
  assign zero_status   = state.zero_flag;
  assign match_status  = state.match_flag;
endmodule
`default_nettype wire

// ### quad_timer_asserts.sv
// assertions for the quad down-counter timer
`timescale 1ns/1ns
`default_nettype none
module quad_timer_asserts
  import quad_timer_pkg::*;
(
  input wire logic                                   clk,
  input wire logic                                   rst,
  input wire logic [timer_count-1:0]                 fixed_write,
  input wire logic [count_width-1:0]                 fixed_data,
  input wire logic [timer_count-1:0]                 load_on_write,
  input wire logic [timer_count-1:0]                 reload,
  input wire logic [timer_count-1:0]                 status_clear,
  input wire logic [timer_count-1:0][count_width-1:0] running_count,
  input wire logic [timer_count-1:0][count_width-1:0] fixed_count,
  input wire logic [timer_count-1:0][count_width-1:0] match_value,
  input wire logic [timer_count-1:0]                 zero_status,
  input wire logic [timer_count-1:0]                 match_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // timer 0 leaves one through a count, not a write
  sequence s_last; running_count[0] == count_one && !fixed_write[0] ##1
    running_count[0] != count_one; endsequence
  property p_fixed; fixed_write[1] |=> fixed_count[1] == $past(fixed_data); endproperty
  a_fixed: assert property (p_fixed) else $error("fixed count not written");
  property p_load; fixed_write[1] && load_on_write[1] |=>
    running_count[1] == $past(fixed_data); endproperty
  a_load: assert property (p_load) else $error("counter not loaded on write");
  property p_zero; s_last |-> zero_status[0]; endproperty
  a_zero: assert property (p_zero) else $error("zero status not set");
  property p_rise; $rose(zero_status[0]) |-> $past(running_count[0]) == count_one; endproperty
  a_rise: assert property (p_rise) else $error("zero status set too early");
  property p_reload; reload[0] ##0 s_last |-> running_count[0] == $past(fixed_count[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero");
  property p_stall; running_count[1] == count_reset && !reload[1] && !fixed_write[1] |=>
    running_count[1] == count_reset; endproperty
  a_stall: assert property (p_stall) else $error("counter left zero");
  property p_step; !fixed_write[0] && running_count[0] > count_one |=> running_count[0] ==
    $past(running_count[0]) || running_count[0] == $past(running_count[0]) - count_one;
  endproperty
  a_step: assert property (p_step) else $error("counter stepped by more than one");
  property p_hold; zero_status[0] && !status_clear[0] |=> zero_status[0]; endproperty
  a_hold: assert property (p_hold) else $error("zero status dropped");
  property p_match; !rst && running_count[0] == match_value[0] |=> match_status[0]; endproperty
  a_match: assert property (p_match) else $error("match status not set");
endmodule
bind quad_down_counter_timer quad_timer_asserts chk (.clk(clk), .rst(rst), .reload(reload),
  .fixed_write(fixed_write), .fixed_data(fixed_data), .load_on_write(load_on_write),
  .status_clear(status_clear), .running_count(running_count), .fixed_count(fixed_count),
  .zero_status(zero_status), .match_value(match_value), .match_status(match_status));
`default_nettype wire

// ### tb_top.sv
// self-checking testbench for the quad down-counter timer
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import quad_timer_pkg::*;
;
  logic             clk = 1'b0, rst = 1'b1, xi = 1'b0;
  logic [7:0]       pw = 8'h00;
  logic [1:0]       xr = 2'h0;
  logic [3:0][3:0]  sel = {select_xtal, 12'h000};
  logic [3:0]       inv = 4'h4, rl = 4'h1, lw = 4'h0, fw = 4'h0, zs;
  logic [3:0]       mw = 4'h0, mc = 4'h0, sc = 4'h0, ms;
  logic [31:0]      fd = 32'h0, md = 32'h0;
  logic [3:0][31:0] fc, rc, mv;
  int               n_errors = 0, compares = 0;
  quad_down_counter_timer dut (.clk(clk), .rst(rst), .pwm_in(pw), .xtal_in(xi), .xtal_rate(xr),
    .source_select(sel), .invert(inv), .reload(rl), .load_on_write(lw), .fixed_write(fw),
    .fixed_data(fd), .match_write(mw), .match_data(md), .status_clear(sc),
    .match_clear(mc), .fixed_count(fc), .running_count(rc), .match_value(mv),
    .zero_status(zs), .match_status(ms));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) n_errors++;
    if (seen !== exp) $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // flip one source pin (8 is the crystal) and let it settle
  task automatic tog(input int b);
    @(posedge clk);
    {xi, pw} <= {xi, pw} ^ (9'h001 << b);
    cyc(5);
  endtask
  task automatic wr(input int t, input logic [31:0] d, input logic l);
    @(posedge clk);
    {fw[t], lw[t], fd} <= {1'b1, l, d};
    @(posedge clk);
    fw[t] <= 1'b0;
    #1;
  endtask
  // timer 0 reloads, timer 1 stalls, timer 2 counts falling edges
  task automatic t_count;
    wr(0, 32'h3, 1'b1);
    wr(1, 32'h2, 1'b1);
    wr(2, 32'h5, 1'b1);
    tog(0);
    chk(rc[2], 32'h5);
    chk(rc[0], 32'h2);
    repeat (5) tog(0);
    chk(rc[0], 32'h3);
    chk(zs[0], 1'b1);
    chk(rc[1], 32'h0);
    chk(rc[2], 32'h2);
    chk(fc[2], 32'h5);
    $display("count test done");
  endtask
  // timer 3 on the crystal at every rate, two prescaled ticks per rate
  task automatic t_xtal;
    int e[4] = '{4, 16, 32, 128};
    wr(3, 32'h9, 1'b1);
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      xr <= r[1:0];
      repeat (e[r]) tog(8);
      chk(rc[3], 32'(7 - 2 * r));
    end
    wr(1, 32'h9, 1'b0);
    chk(rc[1], 32'h0);
    chk(fc[1], 32'h9);
    chk(zs[0], 1'b1);
    $display("crystal test done");
  endtask
  // clear timer 0's zero flag, hit a match by counting, park timer 2 on a dead code
  task automatic t_flags;
    @(posedge clk);
    sc[0] <= 1'b1;
    {mw[0], mc[0], md} <= {1'b1, 1'b1, 32'h2};
    @(posedge clk);
    {sc[0], mw[0], mc[0]} <= 3'h0;
    #1;
    chk(zs[0], 1'b0);
    chk(ms[0], 1'b0);
    chk(mv[0], 32'h2);
    tog(0);
    chk(rc[0], 32'h2);
    chk(ms[0], 1'b1);
    @(posedge clk);
    {sel[2], inv[2]} <= {4'h9, 1'b0};
    repeat (2) tog(0);
    chk(rc[2], 32'h2);
    chk(rc[0], 32'h1);
    chk(ms[0], 1'b1);
    chk(zs[0], 1'b0);
    $display("flag test done");
  endtask
  task automatic end_sim;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_count();
    t_xtal();
    t_flags();
    end_sim();
  end
  // watchdog against a hang
  initial begin
    #50000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
